// File: config_latch_array.sv
/*
  byte-wide latch array standing in for the nonvolatile configuration cells.
  assumes one writer and one reader on the same clock; contents survive reset.
*/
`timescale 1ns/100ps
`default_nettype none
module config_latch_array #(
  parameter int                     WIDTH = 8,
  parameter int                     DEPTH = 4,
  parameter int                     AW    = 2,
  parameter logic [DEPTH*WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output var  logic [WIDTH-1:0] rdata_o
);
  typedef logic [WIDTH-1:0] cell_array_type [DEPTH];

  // factory contents at power-up only; no reset so that writes persist across device resets
  function automatic cell_array_type factory_cells();
    cell_array_type img;
    for (int k = 0; k < DEPTH; k++) begin
      img[k] = INIT[k*WIDTH +: WIDTH];
    end
    return img;
  endfunction

  cell_array_type cells = factory_cells();

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      cells[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= cells[raddr_i];
    end
  end
endmodule
`default_nettype wire

// File: config_latch_loader.sv
/*
  configuration latch loader: latch array behind an avalon-mm slave, captured once
  after every reset and decoded into held device settings.
  assumes bus signals on CORE_CLK_I and an asynchronous active-low reset.
*/
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module config_latch_loader
  import config_latch_pkg::*;
#(
  parameter logic               EXT_RESET_DEFAULT   = 1'b0,
  parameter logic [PHASE_W-1:0] PHASE_DELAY_DEFAULT = 4'h0
) (
  input  wire logic                      CORE_CLK_I,
  input  wire logic                      RSTN_I,
  input  wire logic [ADDR_W-1:0]         AVS_ADDRESS_I,
  input  wire logic                      AVS_READ_I,
  input  wire logic                      AVS_WRITE_I,
  input  wire logic [DATA_W-1:0]         AVS_WRITEDATA_I,
  input  wire logic [3:0]                AVS_BYTEENABLE_I,
  output var  logic [DATA_W-1:0]         AVS_READDATA_O,
  output var  logic                      AVS_WAITREQUEST_O,
  output wire logic [2*PORT_COUNT-1:0]   PORT_RESET_DRIVE_MODE_O,
  output wire logic [PORT_COUNT-1:0]     PORT_PULL_UP_O,
  output wire logic [PORT_COUNT-1:0]     PORT_PULL_DOWN_O,
  output wire logic [PORT_COUNT-1:0]     PORT_DIGITAL_INPUT_O,
  output var  logic                      EXTERNAL_RESET_PIN_ENABLE_O,
  output var  logic                      SHARED_PIN_GPIO_O,
  output var  logic                      DEBUG_JTAG5_O,
  output var  logic                      DEBUG_JTAG4_O,
  output var  logic                      DEBUG_SWD_O,
  output var  logic                      FLASH_CORRECTION_ENABLE_O,
  output var  logic                      FLASH_EXTRA_DATA_O,
  output var  logic [PHASE_W-1:0]        DIGITAL_CLOCK_PHASE_DELAY_O,
  output var  logic                      CONFIG_APPLIED_O,
  output var  logic                      PINS_RELEASE_O
);
  localparam logic [LATCH_W-1:0] DEFAULT_RESET_BYTE =
    {EXT_RESET_DEFAULT, {(LATCH_W-1-DRIVE_W){1'b0}}, MODE_HIZ_ANALOG};
  localparam logic [LATCH_W-1:0] DEFAULT_DEBUG_BYTE =
    {PHASE_DELAY_DEFAULT, DEFAULT_ECC, 1'b0, DEFAULT_DBG};
  localparam logic [LATCH_BYTES*LATCH_W-1:0] FACTORY_IMAGE =
    {DEFAULT_DEBUG_BYTE, DEFAULT_RESET_BYTE, DEFAULT_DRIVE_BYTE, DEFAULT_DRIVE_BYTE};

  loader_state_type               state;
  loader_state_type               next_state;
  logic [LATCH_AW-1:0]            fetch_idx;
  logic [LATCH_AW-1:0]            fetch_slot;
  logic                           fetch_valid;
  logic [LATCH_BYTES-1:0][LATCH_W-1:0] shadow;
  logic [LATCH_W-1:0]             mem_rdata;
  logic [1:0]                     age;
  logic [COUNT_W-1:0]             write_count;
  logic [2*PORT_COUNT-1:0]        mode_q;
  logic [PORT_COUNT-1:0]          pull_up_q;
  logic [PORT_COUNT-1:0]          pull_down_q;
  logic [PORT_COUNT-1:0]          dig_in_q;

  // bus decode
  wire logic [IDX_W-1:0]    word_idx   = AVS_ADDRESS_I[ADDR_W-1:WORD_LSB];
  wire logic                req        = AVS_READ_I | AVS_WRITE_I;
  wire logic                running    = (state == ST_RUN);
  wire logic                hit_latch  = (word_idx <= IDX_DEBUG_CLOCK);
  wire logic                hit_status = (word_idx == IDX_STATUS);
  wire logic                bus_take   = req & AVS_WAITREQUEST_O & running & (age == ANSWER_AGE);
  wire logic                complete   = req & ~AVS_WAITREQUEST_O;
  wire logic                mem_we     = complete & AVS_WRITE_I & hit_latch & AVS_BYTEENABLE_I[0];
  wire logic                count_full = &write_count;
  wire logic [LATCH_AW-1:0] mem_raddr  = running ? word_idx[LATCH_AW-1:0] : fetch_idx;
  wire logic                load       = running & ~CONFIG_APPLIED_O;
  wire logic [DATA_W-1:0]   status_word =
    {write_count, {(DATA_W-COUNT_W-1){1'b0}}, CONFIG_APPLIED_O};
  wire logic [DATA_W-1:0]   rd_word =
    hit_latch  ? {{(DATA_W-LATCH_W){1'b0}}, mem_rdata} :
    hit_status ? status_word : '0;

  // drive mode fields in port order 0..6, 12, 15
  wire logic [2*PORT_COUNT-1:0] port_fields =
    {shadow[IDX_RESET_PORT[LATCH_AW-1:0]][DRIVE_W-1:0],
     shadow[IDX_DRIVE_HIGH[LATCH_AW-1:0]], shadow[IDX_DRIVE_LOW[LATCH_AW-1:0]]};
  wire logic [LATCH_W-1:0] debug_byte = shadow[IDX_DEBUG_CLOCK[LATCH_AW-1:0]];
  wire logic [DBG_W-1:0]   debug_sel  = debug_byte[DBG_LSB +: DBG_W];

  config_latch_array #(
    .WIDTH (LATCH_W),
    .DEPTH (LATCH_BYTES),
    .AW    (LATCH_AW),
    .INIT  (FACTORY_IMAGE)
  ) u_cells (
    .clk_i   (CORE_CLK_I),
    .rstn_i  (RSTN_I),
    .we_i    (mem_we),
    .waddr_i (word_idx[LATCH_AW-1:0]),
    .wdata_i (AVS_WRITEDATA_I[LATCH_W-1:0]),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  // loader sequence: fetch every latch byte, then decode once
  always_comb begin
    case (state)
      ST_FETCH: next_state = (fetch_idx == LAST_LATCH) ? ST_APPLY : ST_FETCH;
      ST_APPLY: next_state = ST_RUN;
      ST_RUN:   next_state = ST_RUN;
      default:  next_state = ST_FETCH;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state       <= ST_FETCH;
      fetch_idx   <= '0;
      fetch_slot  <= '0;
      fetch_valid <= 1'b0;
    end else begin
      state       <= next_state;
      fetch_idx   <= (state == ST_FETCH) ? fetch_idx + 1'b1 : fetch_idx;
      fetch_slot  <= fetch_idx;
      fetch_valid <= (state == ST_FETCH);
    end
  end

  // read data of the array lag the address by one cycle, hence the slot pipeline
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      shadow <= FACTORY_IMAGE;
    end else if (fetch_valid) begin
      shadow[fetch_slot] <= mem_rdata;
    end
  end

  // per-port drive decode, loaded once and then frozen
  for (genvar i = 0; i < PORT_COUNT; i++) begin : g_port
    wire logic [DRIVE_W-1:0] field = port_fields[DRIVE_W*i +: DRIVE_W];
    logic [DRIVE_W-1:0]      mode_r;
    logic                    up_r;
    logic                    down_r;
    logic                    din_r;
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
        mode_r <= MODE_HIZ_ANALOG;
        up_r   <= 1'b0;
        down_r <= 1'b0;
        din_r  <= 1'b0;
      end else if (load) begin
        mode_r <= field;
        up_r   <= (field == MODE_PULL_UP);
        down_r <= (field == MODE_PULL_DOWN);
        din_r  <= (field != MODE_HIZ_ANALOG);
      end
    end
    assign mode_q[DRIVE_W*i +: DRIVE_W] = mode_r;
    assign pull_up_q[i]                 = up_r;
    assign pull_down_q[i]               = down_r;
    assign dig_in_q[i]                  = din_r;

    property p_pullup_code;
      @(posedge CORE_CLK_I) disable iff (!RSTN_I)
      CONFIG_APPLIED_O && up_r |-> mode_r == MODE_PULL_UP && !down_r;
    endproperty
    a_pullup_code: assert property (p_pullup_code) else $error("pull-up without pull-up code");
  end

  assign PORT_RESET_DRIVE_MODE_O = mode_q;
  assign PORT_PULL_UP_O          = pull_up_q;
  assign PORT_PULL_DOWN_O        = pull_down_q;
  assign PORT_DIGITAL_INPUT_O    = dig_in_q;

  // device-wide settings; pins are released only a cycle after they settle
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      EXTERNAL_RESET_PIN_ENABLE_O <= 1'b0;
      SHARED_PIN_GPIO_O           <= 1'b0;
      DEBUG_JTAG5_O               <= 1'b0;
      DEBUG_JTAG4_O               <= 1'b0;
      DEBUG_SWD_O                 <= 1'b0;
      FLASH_CORRECTION_ENABLE_O   <= 1'b0;
      FLASH_EXTRA_DATA_O          <= 1'b0;
      DIGITAL_CLOCK_PHASE_DELAY_O <= '0;
      CONFIG_APPLIED_O            <= 1'b0;
      PINS_RELEASE_O              <= 1'b0;
    end else begin
      if (load) begin
        EXTERNAL_RESET_PIN_ENABLE_O <= port_reset_bit();
        SHARED_PIN_GPIO_O           <= ~port_reset_bit();
        DEBUG_JTAG5_O               <= (debug_sel == DBG_JTAG5);
        DEBUG_JTAG4_O               <= (debug_sel == DBG_JTAG4);
        DEBUG_SWD_O                 <= (debug_sel == DBG_SWD);
        FLASH_CORRECTION_ENABLE_O   <= debug_byte[ECC_BIT];
        FLASH_EXTRA_DATA_O          <= ~debug_byte[ECC_BIT];
        DIGITAL_CLOCK_PHASE_DELAY_O <= debug_byte[PHASE_LSB +: PHASE_W];
        CONFIG_APPLIED_O            <= 1'b1;
      end
      PINS_RELEASE_O <= CONFIG_APPLIED_O;
    end
  end

  function automatic logic port_reset_bit();
    port_reset_bit = shadow[IDX_RESET_PORT[LATCH_AW-1:0]][RESET_PIN_BIT];
  endfunction

  // avalon slave: answer two cycles after the request appears; stalled until loaded
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= '0;
      age               <= '0;
    end else begin
      AVS_WAITREQUEST_O <= ~bus_take;
      if (bus_take) begin
        AVS_READDATA_O <= rd_word;
      end
      if (!req || !AVS_WAITREQUEST_O) begin
        age <= '0;
      end else if (running && age != ANSWER_AGE) begin
        age <= age + 1'b1;
      end
    end
  end

  // wear counter lets software see how often the latches were rewritten since the last reset
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      write_count <= '0;
    end else if (mem_we && !count_full) begin
      write_count <= write_count + 1'b1;
    end
  end

  sequence s_last_fetch;
    fetch_valid && fetch_slot == LAST_LATCH;
  endsequence

  property p_load_done;
    @(posedge CORE_CLK_I) disable iff (!RSTN_I)
    state == ST_FETCH && fetch_idx == '0 |-> ##[1:8] CONFIG_APPLIED_O;
  endproperty
  a_load_done: assert property (p_load_done) else $error("settings not applied after reset");

  property p_analog_hiz;
    @(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CONFIG_APPLIED_O && mode_q[DRIVE_W-1:0] == MODE_HIZ_ANALOG |->
      !pull_up_q[0] && !pull_down_q[0] && !dig_in_q[0];
  endproperty
  a_analog_hiz: assert property (p_analog_hiz) else $error("analog hi-z port drives");

  property p_ecc_from_byte3;
    @(posedge CORE_CLK_I) disable iff (!RSTN_I)
    s_last_fetch |=> ##1 FLASH_CORRECTION_ENABLE_O == $past(mem_rdata[ECC_BIT], 2);
  endproperty
  a_ecc_from_byte3: assert property (p_ecc_from_byte3) else $error("ecc enable not from bit 3");

  property p_reset_pin_role;
    @(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CONFIG_APPLIED_O |-> EXTERNAL_RESET_PIN_ENABLE_O != SHARED_PIN_GPIO_O;
  endproperty
  a_reset_pin_role: assert property (p_reset_pin_role) else $error("shared pin role ambiguous");

  property p_debug_off;
    @(posedge CORE_CLK_I) disable iff (!RSTN_I)
    $rose(CONFIG_APPLIED_O) && $past(debug_sel) == DBG_OFF |->
      !(DEBUG_JTAG5_O || DEBUG_JTAG4_O || DEBUG_SWD_O);
  endproperty
  a_debug_off: assert property (p_debug_off) else $error("debug port on while disabled");

  property p_flash_region;
    @(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CONFIG_APPLIED_O |-> FLASH_EXTRA_DATA_O == !FLASH_CORRECTION_ENABLE_O;
  endproperty
  a_flash_region: assert property (p_flash_region) else $error("flash region use wrong");

  property p_phase_from_byte3;
    @(posedge CORE_CLK_I) disable iff (!RSTN_I)
    s_last_fetch |=> ##1 DIGITAL_CLOCK_PHASE_DELAY_O == $past(mem_rdata[PHASE_LSB +: PHASE_W], 2);
  endproperty
  a_phase_from_byte3: assert property (p_phase_from_byte3) else $error("phase delay mismatch");

  property p_held;
    @(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CONFIG_APPLIED_O |=> CONFIG_APPLIED_O && $stable(mode_q) && $stable(DIGITAL_CLOCK_PHASE_DELAY_O);
  endproperty
  a_held: assert property (p_held) else $error("settings changed after load");

  property p_release_after;
    @(posedge CORE_CLK_I) disable iff (!RSTN_I)
    $rose(PINS_RELEASE_O) |-> $past(CONFIG_APPLIED_O) && CONFIG_APPLIED_O;
  endproperty
  a_release_after: assert property (p_release_after) else $error("pins released too early");

  // software must not see latch contents before the loader has finished with them
  property p_stall_until_applied;
    @(posedge CORE_CLK_I) disable iff (!RSTN_I)
    !CONFIG_APPLIED_O |-> AVS_WAITREQUEST_O;
  endproperty
  a_stall_until_applied: assert property (p_stall_until_applied) else $error("bus answered before load");

  property p_single_answer;
    @(posedge CORE_CLK_I) disable iff (!RSTN_I)
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
  endproperty
  a_single_answer: assert property (p_single_answer) else $error("waitrequest low two cycles");
endmodule
`default_nettype wire

// File: config_latch_pkg.sv
/*
  constants, field layout, codes and state encoding of the configuration latch loader.
  assumes a 32-bit word-aligned register bus and four byte-wide latches.
*/
`default_nettype none
package config_latch_pkg;
  localparam int DATA_W      = 32;
  localparam int ADDR_W      = 5;
  localparam int WORD_LSB    = 2;
  localparam int IDX_W       = 3;
  localparam int LATCH_W     = 8;
  localparam int LATCH_BYTES = 4;
  localparam int LATCH_AW    = 2;
  localparam int PORT_COUNT  = 9;
  localparam int DRIVE_W     = 2;
  localparam int DBG_W       = 2;
  localparam int PHASE_W     = 4;
  localparam int COUNT_W     = 16;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DRIVE_LOW   = 3'h0;
  localparam logic [IDX_W-1:0] IDX_DRIVE_HIGH  = 3'h1;
  localparam logic [IDX_W-1:0] IDX_RESET_PORT  = 3'h2;
  localparam logic [IDX_W-1:0] IDX_DEBUG_CLOCK = 3'h3;
  localparam logic [IDX_W-1:0] IDX_STATUS      = 3'h4;

  // field positions inside the latch bytes
  localparam int RESET_PIN_BIT = 7;
  localparam int ECC_BIT       = 3;
  localparam int DBG_LSB       = 0;
  localparam int PHASE_LSB     = 4;

  typedef enum logic [DRIVE_W-1:0] {
    MODE_HIZ_ANALOG  = 2'h0,
    MODE_HIZ_DIGITAL = 2'h1,
    MODE_PULL_UP     = 2'h2,
    MODE_PULL_DOWN   = 2'h3
  } drive_mode_type;

  typedef enum logic [DBG_W-1:0] {
    DBG_JTAG5 = 2'h0,
    DBG_JTAG4 = 2'h1,
    DBG_SWD   = 2'h2,
    DBG_OFF   = 2'h3
  } debug_select_type;

  typedef enum logic [1:0] {
    ST_FETCH = 2'h0,
    ST_APPLY = 2'h1,
    ST_RUN   = 2'h3
  } loader_state_type;

  localparam logic [LATCH_W-1:0]  DEFAULT_DRIVE_BYTE = 8'h00;
  localparam logic                DEFAULT_ECC        = 1'b0;
  localparam logic [DBG_W-1:0]    DEFAULT_DBG        = 2'h1;
  localparam logic [LATCH_AW-1:0] LAST_LATCH         = 2'h3;
  localparam logic [1:0]          ANSWER_AGE         = 2'h1;
endpackage
`default_nettype wire

// File: tb_reset_config_latch_array.sv
/*
  self-checking bench of the configuration latch loader: byte model, avalon-mm tasks, reset cycles.
  assumes the loader's registered bus answer and latch contents that survive RSTN_I.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_reset_config_latch_array;
  import config_latch_pkg::*;
  logic                    core_clk;
  logic                    rstn;
  logic [ADDR_W-1:0]       avs_address;
  logic                    avs_read;
  logic                    avs_write;
  logic [DATA_W-1:0]       avs_writedata;
  logic [3:0]              avs_byteenable;
  logic [DATA_W-1:0]       avs_readdata;
  logic                    avs_waitrequest;
  logic [2*PORT_COUNT-1:0] drive_mode;
  logic [PORT_COUNT-1:0]   pull_up;
  logic [PORT_COUNT-1:0]   pull_down;
  logic [PORT_COUNT-1:0]   digital_in;
  logic                    ext_reset;
  logic                    shared_gpio;
  logic                    jtag5;
  logic                    jtag4;
  logic                    swd;
  logic                    ecc;
  logic                    extra_data;
  logic [PHASE_W-1:0]      phase;
  logic                    applied;
  logic                    release_pins;
  int                      n_errors;
  int                      checks_done;
  logic [7:0]              lat [4];
  logic [7:0]              live [4];
  logic [15:0]             wcount;
  logic [7:0]              lfsr;
  logic [7:0]              b;

  config_latch_loader #(.EXT_RESET_DEFAULT(1'b1), .PHASE_DELAY_DEFAULT(4'h5)) config_latch_loader_i (
    .CORE_CLK_I(core_clk), .RSTN_I(rstn), .AVS_ADDRESS_I(avs_address), .AVS_READ_I(avs_read),
    .AVS_WRITE_I(avs_write), .AVS_WRITEDATA_I(avs_writedata), .AVS_BYTEENABLE_I(avs_byteenable),
    .AVS_READDATA_O(avs_readdata), .AVS_WAITREQUEST_O(avs_waitrequest),
    .PORT_RESET_DRIVE_MODE_O(drive_mode), .PORT_PULL_UP_O(pull_up), .PORT_PULL_DOWN_O(pull_down),
    .PORT_DIGITAL_INPUT_O(digital_in), .EXTERNAL_RESET_PIN_ENABLE_O(ext_reset),
    .SHARED_PIN_GPIO_O(shared_gpio), .DEBUG_JTAG5_O(jtag5), .DEBUG_JTAG4_O(jtag4), .DEBUG_SWD_O(swd),
    .FLASH_CORRECTION_ENABLE_O(ecc), .FLASH_EXTRA_DATA_O(extra_data),
    .DIGITAL_CLOCK_PHASE_DELAY_O(phase), .CONFIG_APPLIED_O(applied), .PINS_RELEASE_O(release_pins)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic summarize;
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one transfer; request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [DATA_W-1:0] d,
                     input logic [3:0] be, output logic [DATA_W-1:0] q);
    int n;
    @(posedge core_clk);
    lfsr = lfsr_next(lfsr);
    avs_address <= {idx, lfsr[1:0]};
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      n_errors++;
      summarize();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] idx, input logic [DATA_W-1:0] d, input logic [3:0] be);
    logic [DATA_W-1:0] q;
    bus(1'b1, idx, d, be, q);
    if (idx < 3'h4 && be[0]) begin
      lat[idx[1:0]] = d[7:0];
      wcount++;
    end
  endtask

  task automatic rd_chk(input logic [2:0] idx);
    logic [DATA_W-1:0] q;
    logic [DATA_W-1:0] e;
    bus(1'b0, idx, '0, 4'hf, q);
    e = (idx < 3'h4) ? {24'h0, lat[idx[1:0]]} : (idx == 3'h4) ? {wcount, 15'h0, 1'b1} : '0;
    `CHK(q, e)
  endtask

  // bytes written now only show on the outputs after this
  task automatic do_reset;
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK(avs_waitrequest, 1'b1)
    `CHK({applied, release_pins, drive_mode}, '0)
    @(posedge core_clk);
    rstn <= 1'b1;
    wcount = '0;
    live = lat;
    for (int e = 1; e <= 7; e++) begin
      @(posedge core_clk);
      #1;
      `CHK(applied, logic'(e >= 6))
      `CHK(release_pins, logic'(e >= 7))
    end
  endtask

  task automatic check_outputs;
    logic [2*PORT_COUNT-1:0] m;
    logic [PORT_COUNT-1:0]   pu;
    logic [PORT_COUNT-1:0]   pd;
    logic [PORT_COUNT-1:0]   di;
    m = {live[2][1:0], live[1], live[0]};
    for (int i = 0; i < PORT_COUNT; i++) begin
      pu[i] = (m[2*i+:2] == 2'h2);
      pd[i] = (m[2*i+:2] == 2'h3);
      di[i] = (m[2*i+:2] != 2'h0);
    end
    `CHK(drive_mode, m)
    `CHK(pull_up, pu)
    `CHK(pull_down, pd)
    `CHK(digital_in, di)
    `CHK(ext_reset, live[2][7])
    `CHK(shared_gpio, ~live[2][7])
    `CHK({jtag5, jtag4, swd}, {live[3][1:0] == 2'h0, live[3][1:0] == 2'h1, live[3][1:0] == 2'h2})
    `CHK(ecc, live[3][3])
    `CHK(extra_data, ~live[3][3])
    `CHK(phase, live[3][7:4])
    `CHK({applied, release_pins}, 2'h3)
  endtask

  initial begin
    rstn = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = '0;
    n_errors = 0;
    checks_done = 0;
    lfsr = 8'h1a;
    wcount = '0;
    // factory image for the parameters given above
    lat = '{8'h00, 8'h00, 8'h80, 8'h51};
    do_reset();
    check_outputs();
    for (int i = 0; i < 6; i++)
      rd_chk(3'(i));
    // each pass writes every latch once only, to spare cell endurance
    for (int it = 0; it < 4; it++) begin
      for (int i = 0; i < 4; i++) begin
        lfsr = lfsr_next(lfsr);
        b = (it == 0 && i == 0) ? 8'he4 : lfsr;
        if (i == 3)
          b[1:0] = 2'(it);
        wr(3'(i), {~lfsr, lfsr, ~lfsr, b}, 4'hf);
      end
      for (int i = 0; i < 5; i++)
        rd_chk(3'(i));
      check_outputs();
      lfsr = lfsr_next(lfsr);
      wr(3'h4, {4{lfsr}}, 4'hf);
      wr(3'h0, {4{~lfsr}}, 4'he);
      wr(3'h6, {4{lfsr}}, 4'hf);
      rd_chk(3'h0);
      rd_chk(3'h4);
      rd_chk(3'h6);
      check_outputs();
      do_reset();
      check_outputs();
    end
    // request raised while the loader still fetches: stalled until the settings apply
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    wcount = '0;
    live = lat;
    rd_chk(3'h4);
    check_outputs();
    summarize();
  end
endmodule
`default_nettype wire
